// ===== core/srs_sequencer.sv
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module srs_sequencer #(
  parameter int PORTS     = 4,
  parameter int TRAIN_CYC = srs_pkg::TRAIN_CYC,
  parameter int CFG_CYC   = srs_pkg::CFG_READY_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pins
  input  wire logic              fundamental_reset_input_n,
  input  wire logic              reset_halt_pin,
  input  wire logic [2:0]        boot_operating_mode,
  // Link side events, same clock
  input  wire logic              up_ts1_hot_reset,
  input  wire logic              up_dl_down,
  input  wire srs_pkg::srs_req_s stack_req,
  // EEPROM loader, same clock
  input  wire srs_pkg::srs_ee_wr_s ee_wr,
  input  wire logic              ee_last,
  input  wire logic              ee_error,
  input  wire logic [7:0]        ee_err_code,
  // Outputs
  output logic                   link_train_en,
  output logic [PORTS-1:0]       port_retrain,
  output logic                   ee_load_start,
  output logic                   cfg_retry_cpl,
  output logic                   req_drop,
  output logic                   core_reset,
  output logic                   hot_reset_start,
  output logic [PORTS-1:0]       gpio_out,
  output logic [PORTS-1:0]       gpio_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Three stages; a reset or halt pin change counts when stages two and three agree
  logic [2:0] perst_s_q;
  logic [2:0] halt_s_q;
  logic [2:0] mode_s1_q, mode_s2_q, mode_s3_q;
  logic       perst_n_q;   // Filtered reset pin level
  logic       halt_pin_q;  // Filtered halt pin level

  always_ff @(posedge clk) begin
    if (rst) begin
      perst_s_q  <= 3'h0;
      halt_s_q   <= 3'h0;
      mode_s1_q  <= 3'h0;
      mode_s2_q  <= 3'h0;
      mode_s3_q  <= 3'h0;
    end else begin
      perst_s_q  <= {perst_s_q[1:0], fundamental_reset_input_n};
      halt_s_q   <= {halt_s_q[1:0], reset_halt_pin};
      mode_s1_q  <= boot_operating_mode;
      mode_s2_q  <= mode_s1_q;
      mode_s3_q  <= mode_s2_q;
    end
  end

  // Agreement filters
  always_ff @(posedge clk) begin
    if (rst) begin
      perst_n_q  <= 1'b0;
      halt_pin_q <= 1'b0;
    end else begin
      if (perst_s_q[1] == perst_s_q[2]) begin
        perst_n_q <= perst_s_q[2];
      end
      if (halt_s_q[1] == halt_s_q[2]) begin
        halt_pin_q <= halt_s_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic        aw_hold_q, w_hold_q;   // Address or data accepted
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bus_wr;                // Both halves present
  logic [31:0] ctl_q;                 // Switch control register
  logic        sts_halt_q;            // Status halt flag
  logic        smb_done_q, smb_err_q;
  logic [7:0]  smb_code_q;
  logic [31:0] eeintf_q;              // EEPROM interface register
  logic [PORTS-1:0] phy_q;            // Retrain bits, self clearing
  logic        fundamental_reset_request_bit_wr, hot_reset_request_bit_wr;      // Reset request strobes
  logic        cpl_pend_q;            // Reset waits on write response

  assign bus_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // Write address and data taken independently
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready;
      s_axi_wready  <= !w_hold_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (bus_wr) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Offsets above PHY_LINK_STATE_OFS answer with SLVERR
        s_axi_bresp  <= (aw_addr_q > srs_pkg::PHY_LINK_STATE_OFS) ?
                        2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Fundamental reset bit acts only after the write response is taken, hot reset bit at once
  assign fundamental_reset_request_bit_wr = bus_wr && aw_addr_q == srs_pkg::SWITCH_CONTROL_OFS &&
                   w_strb_q[0] && w_data_q[srs_pkg::CTL_FUND_RESET_BIT];
  assign hot_reset_request_bit_wr = bus_wr && aw_addr_q == srs_pkg::SWITCH_CONTROL_OFS &&
                   w_strb_q[0] && w_data_q[srs_pkg::CTL_HOT_RESET_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  srs_pkg::srs_state_e state_q;
  logic [31:0] cnt_q;         // Time since reset cleared
  logic [2:0]  mode_q;        // Sampled boot mode
  logic        perst_prev_q;  // Edge detect on filtered pin
  logic        fundamental_reset_request_bit_pend_q;   // Register reset awaiting response
  logic        warm_q;        // Warm reset from register, high only for its one IDLE cycle
  logic        halt_set;      // Loader error sets halt

  assign halt_set = state_q == srs_pkg::SRS_LOAD && ee_error;

  // Main reset walk
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q      <= srs_pkg::SRS_IDLE;
      cnt_q        <= 32'h0000_0000;
      mode_q       <= 3'h0;
      perst_prev_q <= 1'b0;
      warm_q       <= 1'b0;
    end else begin
      perst_prev_q <= perst_n_q;
      if (state_q != srs_pkg::SRS_IDLE &&
          cnt_q != 32'hFFFF_FFFF) begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
      if (!perst_n_q) begin
        state_q <= srs_pkg::SRS_IDLE;
        warm_q  <= 1'b0;
      end else if (cpl_pend_q && s_axi_bvalid && s_axi_bready) begin
        warm_q  <= 1'b1;
        state_q <= srs_pkg::SRS_IDLE;
      end else begin
        case (state_q)
          srs_pkg::SRS_IDLE: begin
            // Sample mode only on pin release
            if (!perst_prev_q) begin
              mode_q <= mode_s3_q;
            end
            cnt_q   <= 32'h0000_0000;
            warm_q  <= 1'b0;
            state_q <= srs_pkg::SRS_TRAIN;
          end
          srs_pkg::SRS_TRAIN: begin
            // Training starts at once, well under the limit
            if (cnt_q >= 32'(TRAIN_CYC / 2)) begin
              state_q <= srs_pkg::SRS_QUASI;
            end
          end
          srs_pkg::SRS_QUASI: begin
            if (mode_q == srs_pkg::MODE_EEPROM_INIT) begin
              state_q <= srs_pkg::SRS_LOAD;
            end else begin
              state_q <= srs_pkg::SRS_HALT;
            end
          end
          srs_pkg::SRS_LOAD: begin
            if (ee_error || ee_last) begin
              state_q <= srs_pkg::SRS_HALT;
            end
          end
          srs_pkg::SRS_HALT: begin
            // Held until the agent clears halt
            if (!ctl_q[srs_pkg::CTL_RESET_HALT_BIT]) begin
              state_q <= srs_pkg::SRS_NORMAL;
            end
          end
          srs_pkg::SRS_NORMAL: begin
            state_q <= srs_pkg::SRS_NORMAL;
          end
          default: begin
            state_q <= srs_pkg::SRS_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Control, one-shot reset bits never stored
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_q      <= srs_pkg::CTL_RESET_VAL;
      cpl_pend_q <= 1'b0;
      eeintf_q   <= 32'h0000_0000;
    end else begin
      if (bus_wr && aw_addr_q == srs_pkg::SWITCH_CONTROL_OFS &&
          w_strb_q[0]) begin
        ctl_q[srs_pkg::CTL_RESET_HALT_BIT]  <=
          w_data_q[srs_pkg::CTL_RESET_HALT_BIT];
        ctl_q[srs_pkg::CTL_LD_HOT_RESET_REQUEST_BIT_DIS_BIT] <=
          w_data_q[srs_pkg::CTL_LD_HOT_RESET_REQUEST_BIT_DIS_BIT];
      end
      if (halt_set) begin
        ctl_q[srs_pkg::CTL_RESET_HALT_BIT] <= 1'b1;
      end
      ctl_q[srs_pkg::CTL_FUND_RESET_BIT] <= 1'b0;
      ctl_q[srs_pkg::CTL_HOT_RESET_BIT]  <= 1'b0;
      if (fundamental_reset_request_bit_wr) begin
        cpl_pend_q <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        cpl_pend_q <= 1'b0;
      end
      // Reachable in every state, halt included
      if (bus_wr && aw_addr_q == srs_pkg::EEPROM_INTF_OFS) begin
        eeintf_q <= w_data_q;
      end
    end
  end

  // Status and SMBus flags, set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      sts_halt_q <= 1'b0;
      smb_done_q <= 1'b0;
      smb_err_q  <= 1'b0;
      smb_code_q <= 8'h00;
    end else begin
      if (bus_wr && aw_addr_q == srs_pkg::SMBUS_STATUS_OFS &&
          w_data_q[srs_pkg::SMB_DONE_BIT]) begin
        smb_done_q <= 1'b0;
        smb_err_q  <= 1'b0;
      end
      if (state_q == srs_pkg::SRS_TRAIN && halt_pin_q) begin
        sts_halt_q <= 1'b1;
      end
      if (state_q == srs_pkg::SRS_LOAD && (ee_error || ee_last)) begin
        smb_done_q <= 1'b1;
      end
      if (halt_set) begin
        smb_err_q  <= 1'b1;
        smb_code_q <= ee_err_code;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Side effects and outputs

  // Retrain bit set the cycle after the loader write, port_retrain one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      phy_q <= '0;
    end else begin
      phy_q <= '0;
      for (int i = 0; i < PORTS; i++) begin
        if (state_q == srs_pkg::SRS_LOAD && ee_wr.valid &&
            ee_wr.addr == 8'(srs_pkg::PHY_LINK_STATE_OFS + 4 * i) &&
            ee_wr.data[srs_pkg::PHY_RETRAIN_BIT]) begin
          phy_q[i] <= 1'b1;
        end
      end
    end
  end

  // Hot reset triggers, link-down one maskable
  always_ff @(posedge clk) begin
    if (rst) begin
      hot_reset_start <= 1'b0;
    end else begin
      hot_reset_start <= up_ts1_hot_reset || hot_reset_request_bit_wr ||
        (up_dl_down && !ctl_q[srs_pkg::CTL_LD_HOT_RESET_REQUEST_BIT_DIS_BIT]);
    end
  end

  // Stack responses during quasi-reset
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_retry_cpl <= 1'b0;
      req_drop      <= 1'b0;
    end else begin
      cfg_retry_cpl <= stack_req.valid && stack_req.is_cfg &&
                       state_q != srs_pkg::SRS_NORMAL &&
                       state_q != srs_pkg::SRS_IDLE;
      req_drop      <= stack_req.valid && !stack_req.is_cfg &&
                       state_q != srs_pkg::SRS_NORMAL;
    end
  end

  // Other level outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      link_train_en <= 1'b0;
      port_retrain  <= '0;
      ee_load_start <= 1'b0;
      core_reset    <= 1'b1;
      gpio_out      <= '0;
      gpio_oe       <= '0;
    end else begin
      link_train_en <= state_q != srs_pkg::SRS_IDLE;
      port_retrain  <= phy_q;
      ee_load_start <= state_q == srs_pkg::SRS_QUASI &&
                       mode_q == srs_pkg::MODE_EEPROM_INIT;
      core_reset    <= state_q != srs_pkg::SRS_NORMAL;
      gpio_out      <= '0;
      // Downstream reset pins stay inputs after reset
      gpio_oe       <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'h0;
        case (s_axi_araddr)
          srs_pkg::SWITCH_CONTROL_OFS: s_axi_rdata <= ctl_q;
          srs_pkg::SWITCH_STATUS_OFS:
            s_axi_rdata <= {28'h0, 1'b0, state_q == srs_pkg::SRS_NORMAL,
                            warm_q, sts_halt_q};
          srs_pkg::SMBUS_STATUS_OFS:
            s_axi_rdata <= {16'h0, smb_code_q, 6'h0, smb_err_q, smb_done_q};
          srs_pkg::EEPROM_INTF_OFS: s_axi_rdata <= eeintf_q;
          srs_pkg::PHY_LINK_STATE_OFS: s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== core/srs_pkg.sv
`default_nettype none

package srs_pkg;

  // Register byte offsets
  localparam logic [7:0] SWITCH_CONTROL_OFS  = 8'h00;
  localparam logic [7:0] SWITCH_STATUS_OFS   = 8'h04;
  localparam logic [7:0] SMBUS_STATUS_OFS    = 8'h08;
  localparam logic [7:0] EEPROM_INTF_OFS     = 8'h0C;
  localparam logic [7:0] PHY_LINK_STATE_OFS  = 8'h10;

  // Switch control field positions
  localparam int CTL_FUND_RESET_BIT  = 0;
  localparam int CTL_HOT_RESET_BIT   = 1;
  localparam int CTL_RESET_HALT_BIT  = 2;
  localparam int CTL_LD_HOT_RESET_REQUEST_BIT_DIS_BIT = 3;
  // Switch status field positions
  localparam int STS_RESET_HALT_BIT  = 0;
  // SMBus status field positions
  localparam int SMB_DONE_BIT        = 0;
  localparam int SMB_ERR_BIT         = 1;
  // Phy link state field position
  localparam int PHY_RETRAIN_BIT     = 0;

  // Boot mode encoding for reset plus EEPROM load
  localparam logic [2:0] MODE_EEPROM_INIT = 3'h1;

  // Timing figures and derived cycle counts at 10 MHz
  localparam int CLK_HZ         = 10000000;
  localparam int TRAIN_MS       = 20;
  localparam int CFG_READY_MS   = 100;
  localparam int TRAIN_CYC      = TRAIN_MS * (CLK_HZ / 1000);
  localparam int CFG_READY_CYC  = CFG_READY_MS * (CLK_HZ / 1000);

  // Reset values
  localparam logic [31:0] CTL_RESET_VAL = 32'h0000_0000;

  // Sequencer states
  typedef enum logic [2:0] {
    SRS_IDLE   = 3'b000,
    SRS_TRAIN  = 3'b001,
    SRS_QUASI  = 3'b010,
    SRS_LOAD   = 3'b011,
    SRS_HALT   = 3'b100,
    SRS_NORMAL = 3'b101
  } srs_state_e;

  // One EEPROM register write from the loader
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] data;
  } srs_ee_wr_s;

  // Incoming transaction class from the stacks
  typedef struct packed {
    logic valid;
    logic is_cfg;
  } srs_req_s;

endpackage

`default_nettype wire

// ===== testbench/srs_sequencer_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module srs_sequencer_chk #(
  parameter int PORTS = 4
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                fundamental_reset_input_n,
  input wire logic                up_ts1_hot_reset,
  input wire srs_pkg::srs_req_s   stack_req,
  input wire srs_pkg::srs_ee_wr_s ee_wr,
  input wire logic                ee_error,
  input wire logic                ee_load_start,
  input wire logic                link_train_en,
  input wire logic [PORTS-1:0]    port_retrain,
  input wire logic                cfg_retry_cpl,
  input wire logic                req_drop,
  input wire logic                core_reset,
  input wire logic                hot_reset_start,
  input wire logic [PORTS-1:0]    gpio_oe
);
  // Slack over the shortened training count, sync flops included
  localparam int TRN_MAX = 30;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  // Pins float, links train, stacks answer
  AST_GPIO_IN: assert property (gpio_oe == '0)
    else $error("gpio enable raised");
  AST_TRAIN: assert property (
    $rose(fundamental_reset_input_n) |-> ##[1:TRN_MAX] link_train_en)
    else $error("link training late");
  AST_CFG_RETRY: assert property (
    stack_req.valid && stack_req.is_cfg && link_train_en && core_reset
    |=> cfg_retry_cpl) else $error("config retry missing");
  AST_DROP: assert property (
    stack_req.valid && !stack_req.is_cfg && link_train_en && core_reset
    |=> req_drop && !cfg_retry_cpl) else $error("request not dropped");

  ////////////////////////////////////////////////////////////////////////
  // Loader side effects, halting and hot reset start
  AST_LOAD_IN_RESET: assert property (ee_wr.valid |-> core_reset)
    else $error("load write outside reset");
  AST_RETRAIN: assert property (
    ee_wr.valid && ee_wr.addr == 8'h14 && ee_wr.data[0]
    |-> ##2 port_retrain[1]) else $error("retrain pulse missing");
  AST_ERR_HALT: assert property (ee_error |=> core_reset [*8])
    else $error("core released after load error");
  AST_RELEASE: assert property (
    $fell(core_reset) |-> link_train_en && !ee_load_start)
    else $error("released in wrong state");
  AST_HOT_TS1: assert property (
    up_ts1_hot_reset |=> hot_reset_start)
    else $error("hot reset not started");
endmodule

bind srs_sequencer srs_sequencer_chk #(.PORTS(PORTS)) u_chk (
  .clk(clk), .rst(rst),
  .fundamental_reset_input_n(fundamental_reset_input_n),
  .up_ts1_hot_reset(up_ts1_hot_reset), .stack_req(stack_req),
  .ee_wr(ee_wr), .ee_error(ee_error), .ee_load_start(ee_load_start),
  .link_train_en(link_train_en), .port_retrain(port_retrain),
  .cfg_retry_cpl(cfg_retry_cpl), .req_drop(req_drop),
  .core_reset(core_reset), .hot_reset_start(hot_reset_start),
  .gpio_oe(gpio_oe));

`default_nettype wire

// ===== testbench/srs_ee_model.sv
`timescale 1ns/100ps
`default_nettype none

// Serial EEPROM loader stand-in: two writes then finish, or one write then error
module srs_ee_model (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           start,
  input  wire logic           err_en,
  input  wire logic [3:0]     gap,
  output srs_pkg::srs_ee_wr_s ee_wr,
  output logic                ee_last,
  output logic                ee_error,
  output logic [7:0]          ee_err_code
);
  // Config write first, retrain of port 1 last
  localparam logic [7:0]  ADR [2] = '{8'h10, 8'h14};
  localparam logic [31:0] DAT [2] = '{32'h0000_0000, 32'h0000_0001};

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ee_wr = '0;
    ee_last = 1'b0;
    ee_error = 1'b0;
    ee_err_code = 8'h00;
    forever begin
      @(posedge clk);
      if (start && !rst) begin
        for (int i = 0; i < 2; i++) begin
          // Slow image reads when gap is large
          repeat (gap) @(posedge clk);
          ee_wr <= '{1'b1, ADR[i], DAT[i]};
          @(posedge clk);
          // Released bus shows inverted junk, not the last word
          ee_wr <= '{1'b0, ~ADR[i], ~DAT[i]};
          if (err_en) break;
        end
        if (err_en) begin
          ee_error <= 1'b1;
          ee_err_code <= 8'h5A;
        end else begin
          ee_last <= 1'b1;
        end
        @(posedge clk);
        ee_error <= 1'b0;
        ee_last <= 1'b0;
        wait (!start);
      end
    end
  end
endmodule

`default_nettype wire

// ===== testbench/srs_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none

module srs_sequencer_tb;
  logic                clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]          awaddr, araddr, ee_code;
  logic [31:0]         wdata, rdata, seed, rd;
  logic                awready, wready, bvalid, arready, rvalid;
  logic [1:0]          bresp, rresp, rsp;
  logic                pin_n, halt_pin, ts1, dl_down, err_en, dis;
  logic [2:0]          mode;
  logic [3:0]          gap, retrain, gpo, gpoe;
  srs_pkg::srs_req_s   req;
  srs_pkg::srs_ee_wr_s ee_wr;
  logic                ee_last, ee_error, ld, train_en, cpl, drop, core, hot;
  int                  fails, n_compared, n_cfg, n_drop, n_hot, n_wr, cyc;
  int                  e_cfg, e_drop, h0, k;
  int                  n_rt [4];

  srs_sequencer #(.TRAIN_CYC(20), .CFG_CYC(20)) u_dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fundamental_reset_input_n(pin_n), .reset_halt_pin(halt_pin),
    .boot_operating_mode(mode), .up_ts1_hot_reset(ts1),
    .up_dl_down(dl_down), .stack_req(req), .ee_wr(ee_wr),
    .ee_last(ee_last), .ee_error(ee_error), .ee_err_code(ee_code),
    .link_train_en(train_en), .port_retrain(retrain), .ee_load_start(ld),
    .cfg_retry_cpl(cpl), .req_drop(drop), .core_reset(core),
    .hot_reset_start(hot), .gpio_out(gpo), .gpio_oe(gpoe));

  srs_ee_model u_ee (
    .clk(clk), .rst(rst), .start(ld), .err_en(err_en), .gap(gap),
    .ee_wr(ee_wr), .ee_last(ee_last), .ee_error(ee_error),
    .ee_err_code(ee_code));

  ////////////////////////////////////////////////////////////////////////
  // Clock, pulse counters and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    n_cfg += int'(cpl);
    n_drop += int'(drop);
    n_hot += int'(hot);
    n_wr += int'(ee_wr.valid);
    for (int i = 0; i < 4; i++) n_rt[i] += int'(retrain[i]);
    // Whole run needs well under this
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Link-down trigger is the only one the disable bit masks
  function automatic int exp_hot(input int trig, input logic d);
    return (trig == 1 && d) ? 0 : 1;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Write: both halves offered at once, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && t < 200);
    rsp = bresp;
    bready <= 1'b0;
    if (t >= 200) fails++;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int t;
    t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && t < 200);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (t >= 200) fails++;
  endtask

  task automatic sreq(input logic c);
    @(posedge clk);
    req <= '{1'b1, c};
    @(posedge clk);
    req <= '{1'b0, ~c};
  endtask

  // Bounded wait for the core to leave reset
  task automatic wait_norm();
    int t;
    t = 0;
    while (core && t < 600) begin
      @(posedge clk);
      t++;
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, pin_n, halt_pin, ts1, dl_down, err_en} = 6'h20;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = '0;
    {fails, n_compared, n_cfg, n_drop, n_hot, n_wr, cyc} = '0;
    {e_cfg, e_drop} = '0;
    n_rt = '{0, 0, 0, 0};
    req = '0;
    mode = srs_pkg::MODE_EEPROM_INIT;
    gap = 4'hF;
    seed = 32'hD803;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    pin_n <= 1'b1;
    repeat (12) @(posedge clk);
    // Random requests while held in quasi-reset, slow loader
    repeat (6) begin
      seed = xs(seed);
      e_cfg += int'(seed[0]);
      e_drop += int'(!seed[0]);
      sreq(seed[0]);
    end
    wait_norm();
    repeat (4) @(posedge clk);
    chk("cfg_retry", e_cfg, n_cfg);
    chk("req_drop", e_drop, n_drop);
    chk("ee_writes", 2, n_wr);
    chk("retrain1", 1, n_rt[1]);
    chk("retrain0", 0, n_rt[0]);
    chk("train_en", 1, train_en);
    chk("gpio", 0, {gpo, gpoe});
    axi_rd(srs_pkg::SMBUS_STATUS_OFS);
    chk("smb_done", 32'h1, rd & 32'hFFFF);
    // Clear done so the error path has to set it again
    axi_wr(srs_pkg::SMBUS_STATUS_OFS, 32'h1);
    // Warm reset, boot pins changed but old mode kept, loader errors
    mode <= 3'h0;
    err_en <= 1'b1;
    gap <= 4'h0;
    axi_wr(srs_pkg::SWITCH_CONTROL_OFS, 32'h1);
    chk("fundamental_reset_request_bit_resp", 2'h0, rsp);
    chk("core_at_b", 0, core);
    repeat (80) @(posedge clk);
    chk("ee_writes", 3, n_wr);
    chk("halted", 1, core);
    axi_rd(srs_pkg::SMBUS_STATUS_OFS);
    chk("smb_err", 32'h5A03, rd & 32'hFFFF);
    axi_rd(srs_pkg::SWITCH_CONTROL_OFS);
    chk("ctl_halt", 1, rd[srs_pkg::CTL_RESET_HALT_BIT]);
    sreq(1'b1);
    // Pulse lands one edge later, counter one edge after that
    repeat (3) @(posedge clk);
    chk("halt_retry", e_cfg + 1, n_cfg);
    seed = xs(seed);
    axi_wr(srs_pkg::EEPROM_INTF_OFS, seed);
    chk("eeintf_wr", 2'h0, rsp);
    axi_rd(srs_pkg::EEPROM_INTF_OFS);
    chk("eeintf_rd", seed, rd);
    axi_wr(srs_pkg::SWITCH_CONTROL_OFS, 32'h0);
    wait_norm();
    chk("released", 0, core);
    // Warm reset with the halt pin held
    err_en <= 1'b0;
    halt_pin <= 1'b1;
    axi_wr(srs_pkg::SWITCH_CONTROL_OFS, 32'h1);
    repeat (80) @(posedge clk);
    axi_rd(srs_pkg::SWITCH_STATUS_OFS);
    chk("sts_halt", 1, rd[srs_pkg::STS_RESET_HALT_BIT]);
    halt_pin <= 1'b0;
    axi_wr(srs_pkg::SWITCH_CONTROL_OFS, 32'h0);
    wait_norm();
    // Random hot reset triggers, disable bit toggled
    repeat (12) begin
      seed = xs(seed);
      k = seed[1:0] % 3;
      dis = seed[4];
      h0 = n_hot;
      axi_wr(srs_pkg::SWITCH_CONTROL_OFS, {dis, 1'b0, (k == 2), 1'b0});
      @(posedge clk);
      if (k == 0) ts1 <= 1'b1;
      if (k == 1) dl_down <= 1'b1;
      @(posedge clk);
      {ts1, dl_down} <= 2'b00;
      repeat (4) @(posedge clk);
      chk("hot_count", exp_hot(k, dis), n_hot - h0);
      axi_rd(srs_pkg::SWITCH_CONTROL_OFS);
      chk("hot_reset_request_bit_clear", 0, rd[srs_pkg::CTL_HOT_RESET_BIT]);
    end
    axi_rd(8'h80);
    chk("unmapped", 2'h2, rsp);
    axi_wr(8'h80, 32'h0);
    chk("unmapped_wr", 2'h2, rsp);
    finish_test();
  end
endmodule

`default_nettype wire
